// [rtl/sth_top.v]
// Core-side transmit request and host command flags with an APB slave.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sth_regs.vh"

module sth_top #(
  parameter WIDTH = 24,
  parameter AW    = 3
) (
  input  wire             CLK,
  input  wire             RST_N,
  input  wire             PSEL,
  input  wire             PENABLE,
  input  wire             PWRITE,
  input  wire [11:0]      PADDR,
  input  wire [31:0]      PWDATA,
  output reg  [31:0]      PRDATA,
  output wire             PREADY,
  output wire             PSLVERR,
  input  wire             HOST_READ_ACTIVE,
  input  wire             HOST_READ_STROBE,
  input  wire             HOST_FETCH_TYPE,
  input  wire [1:0]       HOST_RX_FORMAT,
  input  wire             HOST_CMD_SET,
  output wire [WIDTH-1:0] HOST_RX_DATA,
  output reg              HOST_RX_VALID,
  output reg              HOST_CMD_BIT,
  input  wire             CORE_HCMD_ACK,
  output wire             STX_IRQ_REQ,
  output wire             STX_DMA_REQ,
  output wire             HCMD_IRQ_REQ,
  output wire             IRQ
);

  // -------------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------------
  localparam [31:0] cap_full_w  = `STH_FIFO_DEPTH;
  localparam [31:0] cap_last_w  = `STH_FIFO_DEPTH - 1;
  localparam [31:0] cap_fmt32_w = `STH_FIFO_DEPTH_32;
  localparam [31:0] cap_ub_w    = `STH_FIFO_DEPTH_UB;

  function [AW-1:0] ptr_next;
    input [AW-1:0] p;
    ptr_next = (p == cap_last_w[AW-1:0]) ? {AW{1'b0}} :
               p + {{(AW-1){1'b0}}, 1'b1};
  endfunction

  function [AW-1:0] capacity;
    input [2:0] mode;
    input       fetch;
    input [1:0] fmt;
    if ((mode != `STH_MODE_PCI) && fetch)
      capacity = cap_ub_w[AW-1:0];
    else if ((mode == `STH_MODE_PCI) && (fmt == `STH_FMT_32BIT))
      capacity = cap_fmt32_w[AW-1:0];
    else
      capacity = cap_full_w[AW-1:0];
  endfunction

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  reg       strobe_prev_q;
  reg       active_prev_q;
  reg       cmd_prev_q;

  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sync1_q       <= 6'h00;
      sync2_q       <= 6'h00;
      strobe_prev_q <= 1'b0;
      active_prev_q <= 1'b0;
      cmd_prev_q    <= 1'b0;
    end
    else
    begin
      sync1_q       <= {HOST_RX_FORMAT, HOST_FETCH_TYPE, HOST_CMD_SET,
                        HOST_READ_STROBE, HOST_READ_ACTIVE};
      sync2_q       <= sync1_q;
      strobe_prev_q <= sync2_q[1];
      active_prev_q <= sync2_q[0];
      cmd_prev_q    <= sync2_q[2];
    end
  end

  wire       host_reading = sync2_q[0];
  wire       host_pop     = sync2_q[1] & ~strobe_prev_q;
  wire       read_start   = sync2_q[0] & ~active_prev_q;
  wire       cmd_set      = sync2_q[2] & ~cmd_prev_q;
  wire       fetch_type   = sync2_q[3];
  wire [1:0] rx_format    = sync2_q[5:4];

  // -------------------------------------------------------------------------
  // APB decode and registers
  // -------------------------------------------------------------------------
  reg  [7:0] control_q;
  reg  [1:0] irq_stat_q;
  reg  [1:0] irq_en_q;
  reg        slave_tx_request_q;
  reg  [AW-1:0] count_q;

  wire       wr_acc  = PSEL & PENABLE & PWRITE;
  wire       rd_set  = PSEL & ~PENABLE & ~PWRITE;
  wire       mapped  = (PADDR == `STH_OFF_STATUS) ||
                       (PADDR == `STH_OFF_CONTROL) ||
                       (PADDR == `STH_OFF_TX_BUFFER) ||
                       (PADDR == `STH_OFF_IRQ_STAT) ||
                       (PADDR == `STH_OFF_IRQ_CLR) ||
                       (PADDR == `STH_OFF_IRQ_EN);
  wire       tx_write = wr_acc & (PADDR == `STH_OFF_TX_BUFFER);
  wire       soft_rst = wr_acc & (PADDR == `STH_OFF_CONTROL) &
                        PWDATA[`STH_CT_SRST];
  wire [2:0] mode     = control_q[`STH_CT_MODE_HI:`STH_CT_MODE_LO];
  wire       pers_rst = (mode == `STH_MODE_PRESET);
  wire       ub_mode  = (mode == `STH_MODE_UB0) || (mode == `STH_MODE_UB1);

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      control_q <= `STH_CT_RESET;
      irq_en_q  <= 2'h0;
      PRDATA    <= 32'h00000000;
    end
    else
    begin
      if (wr_acc && (PADDR == `STH_OFF_CONTROL))
        control_q <= {2'h0, PWDATA[5:0]};
      if (wr_acc && (PADDR == `STH_OFF_IRQ_EN))
        irq_en_q <= PWDATA[1:0];
      if (rd_set)
      begin
        case (PADDR)
          `STH_OFF_STATUS:
            PRDATA <= {21'h000000, count_q, 6'h00, slave_tx_request_q, HOST_CMD_BIT};
          `STH_OFF_CONTROL:  PRDATA <= {24'h000000, control_q};
          `STH_OFF_IRQ_STAT: PRDATA <= {30'h00000000, irq_stat_q};
          `STH_OFF_IRQ_EN:   PRDATA <= {30'h00000000, irq_en_q};
          default:           PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------------
  // Core-to-host buffer
  // -------------------------------------------------------------------------
  reg  [AW-1:0] wr_ptr_q;
  reg  [AW-1:0] rd_ptr_q;
  wire [AW-1:0] cap     = capacity(mode, fetch_type, rx_format);
  wire          full    = (count_q >= cap);
  wire          empty   = (count_q == {AW{1'b0}});
  wire          flush   = pers_rst | soft_rst | (fetch_type & ~host_reading);
  wire          push    = tx_write & ~full & ~flush;
  wire          pop     = host_pop & ~empty & ~flush;

  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      wr_ptr_q      <= {AW{1'b0}};
      rd_ptr_q      <= {AW{1'b0}};
      count_q       <= {AW{1'b0}};
      HOST_RX_VALID <= 1'b0;
    end
    else
    begin
      HOST_RX_VALID <= pop;
      if (flush)
      begin
        wr_ptr_q <= {AW{1'b0}};
        rd_ptr_q <= {AW{1'b0}};
        count_q  <= {AW{1'b0}};
      end
      else
      begin
        if (push)
          wr_ptr_q <= ptr_next(wr_ptr_q);
        if (pop)
          rd_ptr_q <= ptr_next(rd_ptr_q);
        if (push && !pop)
          count_q <= count_q + {{(AW-1){1'b0}}, 1'b1};
        else if (pop && !push)
          count_q <= count_q - {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end

  sth_fifo_mem #(
    .WIDTH (WIDTH),
    .DEPTH (`STH_FIFO_DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk     (CLK),
    .wr_en   (push),
    .wr_addr (wr_ptr_q),
    .wr_data (PWDATA[WIDTH-1:0]),
    .rd_en   (pop),
    .rd_addr (rd_ptr_q),
    .rd_data (HOST_RX_DATA)
  );

  // -------------------------------------------------------------------------
  // Transmit request flag
  // -------------------------------------------------------------------------
  reg ub_req_q;
  reg slave_tx_request_d;

  always @(posedge CLK)
  begin
    if (!RST_N)
      ub_req_q <= 1'b0;
    else if (!host_reading || tx_write || pers_rst)
      ub_req_q <= 1'b0;
    else if (read_start)
      ub_req_q <= 1'b1;
  end

  always @*
  begin
    slave_tx_request_d = 1'b0;
    if (fetch_type)
    begin
      if (!host_reading)
      begin
        slave_tx_request_d = 1'b0;
      end
      else if (ub_mode)
      begin
        slave_tx_request_d = ub_req_q | read_start;
      end
      else
      begin
        slave_tx_request_d = ~full;
      end
    end
    else
    begin
      slave_tx_request_d = ~full;
    end
  end

  always @(posedge CLK)
  begin
    if (!RST_N || soft_rst)
      slave_tx_request_q <= 1'b1;
    else if (pers_rst)
      slave_tx_request_q <= 1'b0;
    else
      slave_tx_request_q <= slave_tx_request_d;
  end

  // -------------------------------------------------------------------------
  // Host command bit
  // -------------------------------------------------------------------------
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      HOST_CMD_BIT <= 1'b0;
    end
    else if (cmd_set)
    begin
      HOST_CMD_BIT <= 1'b1;
    end
    else if (CORE_HCMD_ACK)
    begin
      HOST_CMD_BIT <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Requests and interrupt status
  // -------------------------------------------------------------------------
  reg slave_tx_request_prev_q;
  reg hcp_prev_q;

  assign STX_IRQ_REQ  = slave_tx_request_q & control_q[`STH_CT_SLAVE_TX_IRQ_ENABLE];
  assign STX_DMA_REQ  = slave_tx_request_q & control_q[`STH_CT_DMAE];
  assign HCMD_IRQ_REQ = HOST_CMD_BIT & control_q[`STH_CT_HOST_CMD_IRQ_ENABLE];
  assign IRQ          = |(irq_stat_q & irq_en_q);

  // Rising flags are sticky; a new event wins over a clear in one cycle.
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      slave_tx_request_prev_q <= 1'b1;
      hcp_prev_q  <= 1'b0;
      irq_stat_q  <= 2'h0;
    end
    else
    begin
      slave_tx_request_prev_q <= slave_tx_request_q;
      hcp_prev_q  <= HOST_CMD_BIT;
      if (wr_acc && (PADDR == `STH_OFF_IRQ_CLR))
      begin
        irq_stat_q <= irq_stat_q & ~PWDATA[1:0] |
                      {HOST_CMD_BIT & ~hcp_prev_q, slave_tx_request_q & ~slave_tx_request_prev_q};
      end
      else
      begin
        irq_stat_q <= irq_stat_q |
                      {HOST_CMD_BIT & ~hcp_prev_q, slave_tx_request_q & ~slave_tx_request_prev_q};
      end
    end
  end

endmodule // sth_top

`default_nettype wire

// [pkg/sth_regs.vh]
// Register offsets, field positions, reset values and sizes of the block.
`ifndef STH_REGS_VH
`define STH_REGS_VH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define STH_OFF_STATUS    12'h000
`define STH_OFF_CONTROL   12'h004
`define STH_OFF_TX_BUFFER 12'h008
`define STH_OFF_IRQ_STAT  12'h00c
`define STH_OFF_IRQ_CLR   12'h010
`define STH_OFF_IRQ_EN    12'h014

// ---------------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------------
`define STH_ST_HCP        0
`define STH_ST_SLAVE_TX_REQUEST       1
`define STH_ST_LVL_LO     8
`define STH_ST_LVL_HI     10

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define STH_CT_MODE_LO    0
`define STH_CT_MODE_HI    2
`define STH_CT_SLAVE_TX_IRQ_ENABLE       3
`define STH_CT_HOST_CMD_IRQ_ENABLE       4
`define STH_CT_DMAE       5
`define STH_CT_SRST       6
`define STH_CT_RESET      8'h00

// ---------------------------------------------------------------------------
// Interface modes and host formats
// ---------------------------------------------------------------------------
`define STH_MODE_PRESET   3'h0
`define STH_MODE_PCI      3'h1
`define STH_MODE_UB0      3'h2
`define STH_MODE_UB1      3'h3
`define STH_FMT_32BIT     2'h0

// ---------------------------------------------------------------------------
// Interrupt status bits and buffer sizes
// ---------------------------------------------------------------------------
`define STH_IRQ_SLAVE_TX_REQUEST      0
`define STH_IRQ_HCP       1
`define STH_FIFO_DEPTH    6
`define STH_FIFO_DEPTH_32 3
`define STH_FIFO_DEPTH_UB 1

`endif

// [rtl/sth_fifo_mem.v]
// Small word memory for the core-to-host path with registered read data.
`timescale 1ns/1ps
`default_nettype none

module sth_fifo_mem #(
  parameter WIDTH = 24,
  parameter DEPTH = 6,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             rd_en,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // sth_fifo_mem

`default_nettype wire

// [rtl/sth_dummy_unused.v]
// Intentionally empty.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [bench/sth_checker.sv]
// Assertion checker for the transmit request and host command outputs.
`timescale 1ns/1ps
`default_nettype none
module sth_checker (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic        PSLVERR,
  input wire logic        HOST_READ_ACTIVE,
  input wire logic        HOST_FETCH_TYPE,
  input wire logic        HOST_CMD_SET,
  input wire logic        HOST_CMD_BIT,
  input wire logic        HOST_RX_VALID,
  input wire logic        CORE_HCMD_ACK,
  input wire logic        STX_IRQ_REQ,
  input wire logic        STX_DMA_REQ,
  input wire logic        HCMD_IRQ_REQ,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_fetch_idle;
    HOST_FETCH_TYPE && !HOST_READ_ACTIVE;
  endsequence
  sequence s_cmd_seen;
    ##[1:5] HOST_CMD_BIT;
  endsequence
  a_fetch_idle_quiet: assert property (
    s_fetch_idle [*6] |-> !STX_IRQ_REQ && !STX_DMA_REQ)
    else $error("transmit request while host idle in fetch mode");
  a_cmd_set_seen: assert property (
    $rose(HOST_CMD_SET) |-> s_cmd_seen)
    else $error("host command not seen");
  a_cmd_host_hold: assert property (
    HOST_CMD_BIT && !CORE_HCMD_ACK |=> HOST_CMD_BIT)
    else $error("command bit cleared without service");
  a_cmd_ack_clear: assert property (
    CORE_HCMD_ACK && !$past(HOST_CMD_SET, 2) |=> !HOST_CMD_BIT)
    else $error("command bit kept after service");
  a_cmd_irq_gate: assert property (
    HCMD_IRQ_REQ |-> HOST_CMD_BIT)
    else $error("command interrupt without pending command");
  a_rx_valid_pulse: assert property (
    HOST_RX_VALID |=> !HOST_RX_VALID)
    else $error("receive valid longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0)
    !RST_N |=> !HOST_CMD_BIT && !IRQ && !HCMD_IRQ_REQ)
    else $error("flags not cleared by reset");
  a_unmapped_err: assert property (
    PSEL && PENABLE |->
      PSLVERR == ((PADDR[1:0] != 2'h0) || (PADDR > 12'h014)))
    else $error("bus error flag wrong");
endmodule // sth_checker
bind sth_top sth_checker i_sth_checker (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PSLVERR(PSLVERR), .HOST_READ_ACTIVE(HOST_READ_ACTIVE),
  .HOST_FETCH_TYPE(HOST_FETCH_TYPE), .HOST_CMD_SET(HOST_CMD_SET),
  .HOST_CMD_BIT(HOST_CMD_BIT), .HOST_RX_VALID(HOST_RX_VALID),
  .CORE_HCMD_ACK(CORE_HCMD_ACK), .STX_IRQ_REQ(STX_IRQ_REQ),
  .STX_DMA_REQ(STX_DMA_REQ), .HCMD_IRQ_REQ(HCMD_IRQ_REQ), .IRQ(IRQ)
);
`default_nettype wire

// [bench/sth_host_model.sv]
// Behavioural host driving the read, strobe, format and command pins.
`timescale 1ns/1ps
`default_nettype none
module sth_host_model (
  input  wire logic       clk,
  output var  logic       read_active = 1'b0,
  output var  logic       read_strobe = 1'b0,
  output var  logic       fetch_type = 1'b0,
  output var  logic [1:0] rx_format = 2'h1,
  output var  logic       cmd_set = 1'b0
);
  task automatic levels(input logic act, input logic fetch,
                        input logic [1:0] fmt);
    @(posedge clk);
    read_active <= act;
    fetch_type  <= fetch;
    rx_format   <= fmt;
    repeat (6) @(posedge clk);
  endtask
  // Pulses stay wide and spaced so the synchroniser sees every edge.
  // host only ever sets
  task automatic pulse(input logic cmd);
    @(posedge clk);
    if (cmd)
      cmd_set <= 1'b1;
    else
      read_strobe <= 1'b1;
    repeat (3) @(posedge clk);
    cmd_set     <= 1'b0;
    read_strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // sth_host_model
`default_nettype wire

// [bench/slave_tx_request_host_cmd_flags_test.sv]
// Self-checking bench for the transmit request and host command block.
`timescale 1ns/1ps
`default_nettype none
module slave_tx_request_host_cmd_flags_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        ack = 1'b0;
  logic [31:0] rv;
  logic        err;
  wire  [31:0] prdata;
  wire         pready, pslverr, ra, rs, ft, cs, rxv, cbit;
  wire         sirq, sdma, hirq, irq;
  wire  [1:0]  fmt;
  wire  [23:0] rxd;
  int          failures = 0;
  int          comparisons = 0;
  int          pops = 0;
  always #2 clk = ~clk;
  always @(posedge clk)
    if (rxv === 1'b1)
      pops <= pops + 1;
  sth_top i_sth_top (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .HOST_READ_ACTIVE(ra),
    .HOST_READ_STROBE(rs), .HOST_FETCH_TYPE(ft), .HOST_RX_FORMAT(fmt),
    .HOST_CMD_SET(cs), .HOST_RX_DATA(rxd), .HOST_RX_VALID(rxv),
    .HOST_CMD_BIT(cbit), .CORE_HCMD_ACK(ack), .STX_IRQ_REQ(sirq),
    .STX_DMA_REQ(sdma), .HCMD_IRQ_REQ(hirq), .IRQ(irq)
  );
  sth_host_model i_sth_host_model (
    .clk(clk), .read_active(ra), .read_strobe(rs), .fetch_type(ft),
    .rx_format(fmt), .cmd_set(cs)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rv  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    summarize;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[1:0], 2'h0);
    xfer(1'b0, 12'h00c, 32'h0);
    check(rv, 32'h0);
    xfer(1'b1, 12'h004, 32'h29);
    repeat (3) @(posedge clk);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[1], 1'b1);
    check({sirq, sdma}, 2'h3);
    for (int i = 0; i < 6; i++)
      xfer(1'b1, 12'h008, 32'h100 + i);
    repeat (2) @(posedge clk);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[10:8], 3'h6);
    check(rv[1], 1'b0);
    check({sirq, sdma}, 2'h0);
    i_sth_host_model.pulse(1'b0);
    check(rxd, 24'h000100);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[10:1], 10'h281);
    i_sth_host_model.levels(1'b0, 1'b0, 2'h0);
    xfer(1'b1, 12'h004, 32'h69);
    for (int i = 0; i < 4; i++)
      xfer(1'b1, 12'h008, 32'h20 + i);
    repeat (2) @(posedge clk);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[10:8], 3'h3);
    check(rv[1], 1'b0);
    i_sth_host_model.levels(1'b0, 1'b1, 2'h1);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[10:1], 10'h0);
    i_sth_host_model.levels(1'b1, 1'b1, 2'h1);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[1], 1'b1);
    xfer(1'b1, 12'h004, 32'h2a);
    i_sth_host_model.levels(1'b0, 1'b1, 2'h1);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[1], 1'b0);
    i_sth_host_model.levels(1'b1, 1'b1, 2'h1);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[1], 1'b1);
    xfer(1'b1, 12'h008, 32'h5);
    repeat (2) @(posedge clk);
    xfer(1'b0, 12'h000, 32'h0);
    check(rv[1], 1'b0);
    xfer(1'b1, 12'h004, 32'h10);
    xfer(1'b1, 12'h014, 32'h2);
    i_sth_host_model.pulse(1'b1);
    xfer(1'b0, 12'h000, 32'h0);
    check({rv[0], cbit}, 2'h3);
    check({hirq, irq}, 2'h3);
    xfer(1'b1, 12'h014, 32'h0);
    check(irq, 1'b0);
    xfer(1'b1, 12'h014, 32'h2);
    xfer(1'b1, 12'h010, 32'h2);
    xfer(1'b0, 12'h00c, 32'h0);
    check({rv[1], irq, cbit}, 3'h1);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    check({cbit, hirq}, 2'h0);
    xfer(1'b0, 12'h018, 32'h0);
    check({err, rv}, {1'b1, 32'h0});
    check(pops, 32'd1);
    summarize;
  end
endmodule // slave_tx_request_host_cmd_flags_test
`default_nettype wire
